// *** core/sld_defs.svh ***
// Constants of the serial segment LCD driver
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH

// ==========================================================
// Display geometry
`define SLD_SEG_COUNT       32
`define SLD_ROW_COUNT       4
`define SLD_FRAME_BITS      8'd128
`define SLD_BIT_CNT_MAX     8'hff
`define SLD_CMD_LSB         0

// ==========================================================
// Frame timing
`define SLD_TICK_LAST       5'd23
`define SLD_SLOT_TICKS_4    5'd6
`define SLD_SLOT_TICKS_3    5'd8
`define SLD_CLK_HZ          100000000
`define SLD_RC_OSC_HZ       4800

// ==========================================================
// Register map
`define SLD_ADDR_CTRL       4'h0
`define SLD_ADDR_STATUS     4'h4
`define SLD_ADDR_FRAMES     4'h8
`define SLD_ADDR_LOADS      4'hc
`define SLD_CTRL_RESET      1'h1
`define SLD_CTRL_DISP_BIT   0
`define SLD_STAT_DUTY_BIT   0
`define SLD_STAT_EXT_BIT    1
`define SLD_STAT_POL_BIT    2
`define SLD_STAT_FULL_BIT   3
`define SLD_STAT_CMD_LSB    8
`define SLD_STAT_DROP_LSB   16

`endif

// *** core/sld_pkg.sv ***
// Types of the serial segment LCD driver
package sld_pkg;

  typedef struct packed {
    logic serial_data;
    logic shift_clk;
    logic load_strobe;
  } sld_link_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } sld_apb_req_type;

  typedef enum logic [1:0] {
    SLD_IDLE = 2'b01,
    SLD_COPY = 2'b10
  } sld_copy_state_type;

  typedef logic [127:0] sld_frame_type;

endpackage

// *** core/sld_mem.sv ***
// Display latch: four rows of segment bits, registered read
`timescale 1ns/100ps
`include "sld_defs.svh"

module sld_mem (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        we,
  input  wire logic [1:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [1:0]  raddr,
  output logic      [31:0] rdata
);

  logic [31:0] mem [0:`SLD_ROW_COUNT-1];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < `SLD_ROW_COUNT; i++) begin
        mem[i] <= 32'h0000_0000;
      end
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule

// *** core/sld_core.sv ***
// Serial segment LCD driver core with APB status and control
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "sld_defs.svh"

// How it works
// - A high serial data bit lights its segment, a low bit darkens it.
// - A data bit is shifted in at every rising edge of the shift clock.
// - A load strobe pulse moves shifted data to the latch or takes a command.
// - Select low uses the built-in RC oscillator, high the external clock.
// - The built-in oscillator is held stopped while the select is high.
// - Duty select high gives 1/3 duty, low gives 1/4 duty.
// - A low level on the reset input initialises all internal state.
// - In 1/3 duty only the first three commons carry a waveform.
// - In 1/4 duty all four commons fire, one per frame slot.
// - The frame rate is the selected oscillator divided by 24.
// - Thirty-two segment outputs follow the latched data of the row.
// - The latch holds 128 segments in both duties; 1/3 duty only shows the first 96.

module sld_core #(
  parameter int RC_DIV = `SLD_CLK_HZ / `SLD_RC_OSC_HZ
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   ce,
  input  wire sld_pkg::sld_link_type  link,
  input  wire logic                   reset_n,
  input  wire logic                   osc_source_select,
  input  wire logic                   duty_select,
  input  wire logic                   ext_osc_in,
  input  wire sld_pkg::sld_apb_req_type apb_req,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  output logic                        common_out_1,
  output logic                        common_out_2,
  output logic                        common_out_3,
  output logic                        common_out_4,
  output logic [31:0]                 segment_outputs,
  output logic                        frame_rate,
  output logic                        lcd_polarity
);

  // ==========================================================
  // Functions
  function automatic logic [31:0] row_of(input sld_pkg::sld_frame_type f,
                                         input logic [1:0] r);
    case (r)
      2'h0:    row_of = f[127:96];
      2'h1:    row_of = f[95:64];
      2'h2:    row_of = f[63:32];
      default: row_of = f[31:0];
    endcase
  endfunction

  function automatic logic [1:0] slot_of(input logic [4:0] t,
                                         input logic       third);
    if (third) begin
      slot_of = (t < `SLD_SLOT_TICKS_3) ? 2'h0 :
                (t < 5'(2 * `SLD_SLOT_TICKS_3)) ? 2'h1 : 2'h2;
    end else begin
      slot_of = (t < `SLD_SLOT_TICKS_4) ? 2'h0 :
                (t < 5'(2 * `SLD_SLOT_TICKS_4)) ? 2'h1 :
                (t < 5'(3 * `SLD_SLOT_TICKS_4)) ? 2'h2 : 2'h3;
    end
  endfunction

  logic rst;
  assign rst = srst | ~reset_n;

  // ==========================================================
  // Serial link, two-entry frame buffer and latch copy
  sld_pkg::sld_link_type       link_q, next_link_q;
  sld_pkg::sld_frame_type      sreg, next_sreg;
  logic [7:0]                  bit_cnt, next_bit_cnt;
  logic [7:0]                  cmd, next_cmd;
  sld_pkg::sld_frame_type      buf_data [0:1];
  sld_pkg::sld_frame_type      next_buf_data [0:1];
  logic                        buf_wr, next_buf_wr;
  logic                        buf_rd, next_buf_rd;
  logic [1:0]                  buf_cnt, next_buf_cnt;
  sld_pkg::sld_copy_state_type copy_state, next_copy_state;
  logic [1:0]                  copy_row, next_copy_row;
  logic [15:0]                 load_cnt, next_load_cnt;
  logic [7:0]                  drop_cnt, next_drop_cnt;
  logic                        shift_rise, load_rise, push, pop;
  logic                        in_ready, out_valid, frame_tick;
  logic                        mem_we;
  logic [31:0]                 mem_wdata, mem_rdata;

  assign shift_rise = link.shift_clk & ~link_q.shift_clk;
  assign load_rise  = link.load_strobe & ~link_q.load_strobe;
  assign in_ready   = (buf_cnt != 2'h2);
  assign out_valid  = (buf_cnt != 2'h0);
  assign mem_we     = (copy_state == sld_pkg::SLD_COPY);
  assign mem_wdata  = row_of(buf_data[buf_rd], copy_row);

  always_comb begin
    next_link_q     = link;
    next_sreg       = sreg;
    next_bit_cnt    = bit_cnt;
    next_cmd        = cmd;
    next_buf_data   = buf_data;
    next_buf_wr     = buf_wr;
    next_buf_rd     = buf_rd;
    next_copy_state = copy_state;
    next_copy_row   = copy_row;
    next_load_cnt   = load_cnt;
    next_drop_cnt   = drop_cnt;
    push            = 1'b0;
    pop             = 1'b0;
    if (shift_rise) begin
      next_sreg = {sreg[126:0], link.serial_data};
      if (bit_cnt != `SLD_BIT_CNT_MAX) begin
        next_bit_cnt = bit_cnt + 8'h01;
      end
    end
    if (load_rise) begin
      next_bit_cnt = 8'h00;
      if (bit_cnt == `SLD_FRAME_BITS) begin
        push = in_ready;
        if (!in_ready) begin
          next_drop_cnt = drop_cnt + 8'h01;
        end
      end else begin
        next_cmd = sreg[`SLD_CMD_LSB +: 8];
      end
    end
    if (push) begin
      next_buf_data[buf_wr] = sreg;
      next_buf_wr           = ~buf_wr;
      next_load_cnt         = load_cnt + 16'h0001;
    end
    case (copy_state)
      sld_pkg::SLD_IDLE: begin
        // Latch only changes on a frame boundary to avoid tearing
        if (out_valid && frame_tick) begin
          next_copy_state = sld_pkg::SLD_COPY;
          next_copy_row   = 2'h0;
        end
      end
      sld_pkg::SLD_COPY: begin
        next_copy_row = copy_row + 2'h1;
        if (copy_row == 2'h3) begin
          pop             = 1'b1;
          next_copy_state = sld_pkg::SLD_IDLE;
        end
      end
      default: next_copy_state = sld_pkg::SLD_IDLE;
    endcase
    if (pop) begin
      next_buf_rd = ~buf_rd;
    end
    next_buf_cnt = 2'(buf_cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_q      <= '0;
      sreg        <= '0;
      bit_cnt     <= 8'h00;
      cmd         <= 8'h00;
      buf_data[0] <= '0;
      buf_data[1] <= '0;
      buf_wr      <= 1'b0;
      buf_rd      <= 1'b0;
      buf_cnt     <= 2'h0;
      copy_state  <= sld_pkg::SLD_IDLE;
      copy_row    <= 2'h0;
      load_cnt    <= 16'h0000;
      drop_cnt    <= 8'h00;
    end else if (ce) begin
      link_q      <= next_link_q;
      sreg        <= next_sreg;
      bit_cnt     <= next_bit_cnt;
      cmd         <= next_cmd;
      buf_data    <= next_buf_data;
      buf_wr      <= next_buf_wr;
      buf_rd      <= next_buf_rd;
      buf_cnt     <= next_buf_cnt;
      copy_state  <= next_copy_state;
      copy_row    <= next_copy_row;
      load_cnt    <= next_load_cnt;
      drop_cnt    <= next_drop_cnt;
    end
  end

  // ==========================================================
  // Oscillator source, frame divider and drive
  logic [23:0] rc_cnt, next_rc_cnt;
  logic        ext_q, next_ext_q;
  logic [4:0]  tick_cnt, next_tick_cnt;
  logic [1:0]  slot, slot_d, next_slot_d;
  logic [31:0] frame_cnt, next_frame_cnt;
  logic        display_on;
  logic        rc_tick, ext_rise, osc_tick;
  logic [3:0]  next_com;
  logic [31:0] next_seg;
  logic        next_frame_rate, next_pol;

  assign rc_tick    = (rc_cnt == 24'(RC_DIV - 1));
  assign ext_rise   = ext_osc_in & ~ext_q;
  assign osc_tick   = osc_source_select ? ext_rise : rc_tick;
  assign frame_tick = osc_tick && (tick_cnt == `SLD_TICK_LAST);
  assign slot       = slot_of(tick_cnt, duty_select);

  always_comb begin
    next_ext_q      = ext_osc_in;
    next_rc_cnt     = rc_tick ? 24'h00_0000 : rc_cnt + 24'h00_0001;
    if (osc_source_select) begin
      next_rc_cnt = 24'h00_0000;
    end
    next_tick_cnt   = tick_cnt;
    if (osc_tick) begin
      next_tick_cnt = frame_tick ? 5'h00 : tick_cnt + 5'h01;
    end
    next_frame_rate = frame_tick;
    next_pol        = frame_tick ? ~lcd_polarity : lcd_polarity;
    next_frame_cnt  = frame_tick ? frame_cnt + 32'h0000_0001 : frame_cnt;
    next_slot_d     = slot;
    next_com        = 4'h0;
    if (display_on) begin
      next_com[slot_d] = 1'b1;
    end
    next_seg        = display_on ? mem_rdata : 32'h0000_0000;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rc_cnt          <= 24'h00_0000;
      ext_q           <= 1'b0;
      tick_cnt        <= 5'h00;
      slot_d          <= 2'h0;
      frame_cnt       <= 32'h0000_0000;
      frame_rate      <= 1'b0;
      lcd_polarity    <= 1'b0;
      common_out_1    <= 1'b0;
      common_out_2    <= 1'b0;
      common_out_3    <= 1'b0;
      common_out_4    <= 1'b0;
      segment_outputs <= 32'h0000_0000;
    end else if (ce) begin
      rc_cnt          <= next_rc_cnt;
      ext_q           <= next_ext_q;
      tick_cnt        <= next_tick_cnt;
      slot_d          <= next_slot_d;
      frame_cnt       <= next_frame_cnt;
      frame_rate      <= next_frame_rate;
      lcd_polarity    <= next_pol;
      common_out_1    <= next_com[0];
      common_out_2    <= next_com[1];
      common_out_3    <= next_com[2];
      common_out_4    <= next_com[3];
      segment_outputs <= next_seg;
    end
  end

  // Display latch, 4 rows of 32 segments
  sld_mem u_mem (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .we      (mem_we),
    .waddr   (copy_row),
    .wdata   (mem_wdata),
    .raddr   (slot),
    .rdata   (mem_rdata)
  );

  // ==========================================================
  // APB slave, one wait state
  logic        next_pready, next_pslverr;
  logic [31:0] next_prdata;
  logic        next_display_on;
  logic        mapped;
  logic [31:0] status_word;

  assign mapped = (apb_req.paddr[31:4] == 28'h000_0000) &&
                  (apb_req.paddr[1:0] == 2'h0);
  assign status_word = {8'h00, drop_cnt, cmd, 4'h0, ~in_ready,
                        lcd_polarity, osc_source_select, duty_select};

  always_comb begin
    next_pready     = 1'b0;
    next_prdata     = prdata;
    next_pslverr    = 1'b0;
    next_display_on = display_on;
    if (apb_req.psel && apb_req.penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = ~mapped;
      case (apb_req.paddr[3:0])
        `SLD_ADDR_CTRL:   next_prdata = {31'h0000_0000, display_on};
        `SLD_ADDR_STATUS: next_prdata = status_word;
        `SLD_ADDR_FRAMES: next_prdata = frame_cnt;
        `SLD_ADDR_LOADS:  next_prdata = {16'h0000, load_cnt};
        default:          next_prdata = 32'h0000_0000;
      endcase
      if (!mapped) begin
        next_prdata = 32'h0000_0000;
      end
    end
    if (apb_req.psel && apb_req.penable && pready && apb_req.pwrite &&
        mapped && apb_req.paddr[3:0] == `SLD_ADDR_CTRL) begin
      next_display_on = apb_req.pwdata[`SLD_CTRL_DISP_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready     <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
      display_on <= `SLD_CTRL_RESET;
    end else if (ce) begin
      pready     <= next_pready;
      prdata     <= next_prdata;
      pslverr    <= next_pslverr;
      display_on <= next_display_on;
    end
  end

  // ==========================================================
  // Assertions
  property p_lit_data;
    @(posedge clk_sys) disable iff (rst)
      copy_state == sld_pkg::SLD_COPY && copy_row == 2'h0 && ce |=>
        u_mem.mem[0] == $past(buf_data[buf_rd][127:96]);
  endproperty
  a_lit_data: assert property (p_lit_data)
    else $error("Latched row differs from shifted data");

  property p_shift_in;
    @(posedge clk_sys) disable iff (rst)
      ce && shift_rise |=>
        sreg == {$past(sreg[126:0]), $past(link.serial_data)};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("Shift edge did not take the data bit");

  property p_load_push;
    @(posedge clk_sys) disable iff (rst)
      ce && load_rise && bit_cnt == `SLD_FRAME_BITS && in_ready |=>
        load_cnt == $past(load_cnt) + 16'h0001 && bit_cnt == 8'h00;
  endproperty
  a_load_push: assert property (p_load_push)
    else $error("Load strobe did not accept a full frame");

  property p_ext_source;
    @(posedge clk_sys) disable iff (rst)
      ce && osc_source_select && !ext_rise |=> $stable(tick_cnt);
  endproperty
  a_ext_source: assert property (p_ext_source)
    else $error("Frame advanced without an external clock edge");

  property p_rc_off;
    @(posedge clk_sys) disable iff (rst)
      ce && osc_source_select |=> rc_cnt == 24'h00_0000;
  endproperty
  a_rc_off: assert property (p_rc_off)
    else $error("Internal oscillator ran while disabled");

  property p_third_duty;
    @(posedge clk_sys) disable iff (rst)
      duty_select && $past(duty_select) && $past(duty_select, 2) |->
        !common_out_4;
  endproperty
  a_third_duty: assert property (p_third_duty)
    else $error("Fourth common driven in one-third duty");

  property p_reset;
    @(posedge clk_sys) disable iff (srst)
      !reset_n |=> bit_cnt == 8'h00 && segment_outputs == 32'h0000_0000 &&
        copy_state == sld_pkg::SLD_IDLE && buf_cnt == 2'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("Reset input did not initialise state");

  property p_com_one;
    @(posedge clk_sys) disable iff (rst)
      $onehot0({common_out_4, common_out_3, common_out_2, common_out_1});
  endproperty
  a_com_one: assert property (p_com_one)
    else $error("More than one common active");

  property p_frame_div;
    @(posedge clk_sys) disable iff (rst)
      $rose(frame_rate) |-> tick_cnt == 5'h00 &&
        $past(tick_cnt) == `SLD_TICK_LAST;
  endproperty
  a_frame_div: assert property (p_frame_div)
    else $error("Frame pulse not after 24 oscillator ticks");

  property p_seg_follow;
    @(posedge clk_sys) disable iff (rst)
      ce && display_on |=> segment_outputs == $past(mem_rdata);
  endproperty
  a_seg_follow: assert property (p_seg_follow)
    else $error("Segments do not follow latched row");

  property p_copy_start;
    @(posedge clk_sys) disable iff (rst)
      copy_state == sld_pkg::SLD_COPY &&
        $past(copy_state) == sld_pkg::SLD_IDLE |->
        $past(frame_tick) && $past(buf_cnt) != 2'h0;
  endproperty
  a_copy_start: assert property (p_copy_start)
    else $error("Latch update without a loaded frame");

endmodule

// *** tb/sld_host_model.sv ***
// Host side model driving the three-wire display link
`timescale 1ns/100ps

module sld_host_model #(
  parameter int HOLD = 2
) (
  input  wire logic             clk_sys,
  output sld_pkg::sld_link_type link
);
  initial link = '0;

  task automatic pass(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Load pulse that commits the shifted data
  task automatic load();
    pass(HOLD);
    link.load_strobe <= 1'b1;
    pass(HOLD);
    link.load_strobe <= 1'b0;
    pass(HOLD);
  endtask

  // Shift n bits, top bit first, optionally followed by a load
  task automatic shift(input logic [127:0] v, input int n, input bit ld);
    for (int i = n - 1; i >= 0; i--) begin
      link.serial_data <= v[i];
      pass(HOLD);
      link.shift_clk <= 1'b1;
      pass(HOLD);
      link.shift_clk <= 1'b0;
    end
    // Released data line no longer shows the last bit
    link.serial_data <= ~v[0];
    if (ld)
      load();
  endtask
endmodule

// *** tb/serial_segment_lcd_driver_tb_top.sv ***
// Self-checking testbench of the serial segment LCD driver
`timescale 1ns/100ps

module serial_segment_lcd_driver_tb_top;
  localparam logic [127:0] F1 = 128'h80000001_0f0f00ff_a5a5c3c3_12345678;
  localparam logic [127:0] F2 = ~F1;
  logic                     clk_sys = 1'b0;
  logic                     srst = 1'b1;
  logic                     ce = 1'b1;
  logic                     reset_n = 1'b1;
  logic                     osc_source_select = 1'b0;
  logic                     duty_select = 1'b0;
  logic                     ext_osc_in = 1'b0;
  logic                     ext_run = 1'b0;
  logic [1:0]               ext_cnt = 2'h0;
  sld_pkg::sld_apb_req_type apb_req = '0;
  sld_pkg::sld_link_type    link;
  logic                     pready;
  logic [31:0]              prdata;
  logic                     pslverr;
  logic                     common_out_1;
  logic                     common_out_2;
  logic                     common_out_3;
  logic                     common_out_4;
  logic [31:0]              segment_outputs;
  logic                     frame_rate;
  logic                     lcd_polarity;
  logic [3:0]               com;
  logic [31:0]              rd;
  logic                     er;
  logic [3:0]               seen;
  int                       n_errors = 0;
  int                       n_checks = 0;
  int                       c;

  assign com = {common_out_4, common_out_3, common_out_2, common_out_1};
  always #5 clk_sys = ~clk_sys;

  // External oscillator, six clocks a period
  always @(posedge clk_sys) begin
    ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
    if (ext_run && ext_cnt == 2'h2)
      ext_osc_in <= ~ext_osc_in;
  end

  sld_host_model #(.HOLD(2)) host (.clk_sys(clk_sys), .link(link));

  sld_core #(.RC_DIV(4)) dut (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .link(link),
    .reset_n(reset_n), .osc_source_select(osc_source_select),
    .duty_select(duty_select), .ext_osc_in(ext_osc_in),
    .apb_req(apb_req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .common_out_1(common_out_1),
    .common_out_2(common_out_2), .common_out_3(common_out_3),
    .common_out_4(common_out_4), .segment_outputs(segment_outputs),
    .frame_rate(frame_rate), .lcd_polarity(lcd_polarity)
  );

  task automatic results();
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    int k;
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= wd;
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    // Idle edge so a following call never re-raises psel in this step
    @(posedge clk_sys);
    if (k >= 50) begin
      n_errors++;
      results();
    end
  endtask

  task automatic wait_frame();
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (frame_rate !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      n_errors++;
      results();
    end
  endtask

  // Wait the given number of frames, then for 200 clocks compare each lit row with its row of the given frame
  task automatic scan(input logic [127:0] f, input int frames);
    repeat (frames) wait_frame();
    seen = 4'h0;
    repeat (200) begin
      @(negedge clk_sys);
      for (int r = 0; r < 4; r++)
        if (com[r] === 1'b1) begin
          seen[r] = 1'b1;
          chk(segment_outputs, f[127 - 32 * r -: 32]);
        end
    end
    // Back on a rising edge before the next stimulus
    @(posedge clk_sys);
  endtask

  task automatic t_regs();
    apb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 32'h4, 32'h0000ff00);
    apb(1'b0, 32'h4, 32'h0);
    chk({rd[15:8], 6'h0, rd[1:0]}, 32'h0);
    apb(1'b0, 32'h10, 32'h0);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask

  task automatic t_frame();
    host.shift(F1, 128, 1'b1);
    apb(1'b0, 32'hc, 32'h0);
    chk(rd[15:0], 16'h1);
    scan(F1, 2);
    chk(seen, 4'hf);
    apb(1'b1, 32'h0, 32'h0);
    scan(F1, 2);
    chk(seen, 4'h0);
    apb(1'b1, 32'h0, 32'h1);
  endtask

  task automatic t_hold();
    host.shift(F2, 128, 1'b0);
    scan(F1, 2);
    host.load();
    scan(F2, 2);
  endtask

  task automatic t_cmd();
    host.shift(128'h5a, 8, 1'b1);
    apb(1'b0, 32'h4, 32'h0);
    chk(rd[15:8], 8'h5a);
    scan(F2, 2);
  endtask

  task automatic t_third();
    duty_select <= 1'b1;
    scan(F2, 2);
    chk(seen, 4'h7);
    apb(1'b0, 32'h4, 32'h0);
    chk(rd[0], 1'b1);
    duty_select <= 1'b0;
    scan(F2, 2);
    chk(seen, 4'hf);
  endtask

  task automatic t_rate();
    logic        p0;
    logic [31:0] f0;
    wait_frame();
    apb(1'b0, 32'h8, 32'h0);
    f0 = rd;
    wait_frame();
    apb(1'b0, 32'h8, 32'h0);
    chk(rd - f0, 32'h0000_0001);
    wait_frame();
    @(negedge clk_sys);
    p0 = lcd_polarity;
    wait_frame();
    chk(c, 96);
    @(negedge clk_sys);
    chk({31'h0000_0000, lcd_polarity}, {31'h0000_0000, ~p0});
    @(posedge clk_sys);
    osc_source_select <= 1'b1;
    ext_run <= 1'b1;
    wait_frame();
    wait_frame();
    chk(c, 144);
    ext_run <= 1'b0;
    // Let the last external edge settle; no frame may follow
    repeat (8) @(posedge clk_sys);
    c = 0;
    repeat (400) begin
      @(posedge clk_sys);
      if (frame_rate === 1'b1)
        c++;
    end
    chk(c, 0);
  endtask

  task automatic t_buffer();
    host.shift(F2, 128, 1'b1);
    host.shift(F1, 128, 1'b1);
    host.shift(F2, 128, 1'b1);
    apb(1'b0, 32'h4, 32'h0);
    chk({rd[23:16], rd[3], rd[1]}, 10'h007);
    apb(1'b0, 32'hc, 32'h0);
    chk(rd[15:0], 16'h4);
    ext_run <= 1'b1;
    scan(F1, 4);
    apb(1'b0, 32'h4, 32'h0);
    chk(rd[3], 1'b0);
    osc_source_select <= 1'b0;
    ext_run <= 1'b0;
  endtask

  task automatic t_reset();
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h0);
    scan(128'h0, 2);
    chk(seen, 4'hf);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_frame();
    t_hold();
    t_cmd();
    t_third();
    t_rate();
    t_buffer();
    t_reset();
    results();
  end
endmodule
